// >>> rtl/kbdscn_consts.svh
/*
  Constants of the keyboard scan, debounce and character queue block.
  Assumes a 40 MHz core clock; the intersection dwell count below is derived from that rate.
*/
`ifndef KBDSCN_CONSTS_SVH
`define KBDSCN_CONSTS_SVH

// core clock period and the debounce window, in their own units
`define KBDSCN_CLK_NS 25
`define KBDSCN_DEBOUNCE_US 11000
`define KBDSCN_DEBOUNCE_SCANS 4
`define KBDSCN_STEPS_PER_SCAN 256
// one intersection dwell: debounce window over four scans of 64 steps, rounded down
`define KBDSCN_STEP_CYC ((`KBDSCN_DEBOUNCE_US * 1000) / (`KBDSCN_CLK_NS * `KBDSCN_STEPS_PER_SCAN))
`define KBDSCN_STEP_W 11
`define KBDSCN_LAST_DEB 3'h3

// character queue
`define KBDSCN_FIFO_SLOTS 4'h8
`define KBDSCN_OVERRUN_STATUS 4'hF
`define KBDSCN_CHAR_SHIFT_BIT 6
`define KBDSCN_CHAR_CTRL_BIT 7

// command queue in front of the core
`define KBDSCN_CMD_WIDTH 7
`define KBDSCN_CMD_DEPTH 16

// strobe reset value and last scan index
`define KBDSCN_STROBE_RST 8'h01
`define KBDSCN_LAST_IDX 3'h7

`endif

// >>> rtl/kbdscn_pkg.sv
/*
  Types of the keyboard scan, debounce and character queue block.
  Assumes the constants header is compiled alongside.
*/
package kbdscn_pkg;

  typedef enum logic [1:0] {KBDSCN_MODE_SCANNED, KBDSCN_MODE_ENCODED, KBDSCN_MODE_SENSOR} kbdscn_kmode_t;

  typedef enum logic [2:0] {
    KBDSCN_CMD_STATUS_RD,
    KBDSCN_CMD_FIRST_NIBBLE_RD,
    KBDSCN_CMD_SECOND_NIBBLE_READ_CMD,
    KBDSCN_CMD_CLEAR_LOGIC_CMD,
    KBDSCN_CMD_ALTERNATE_CLEAR_CMD,
    KBDSCN_CMD_DISP_WR,
    KBDSCN_CMD_DISP_PTR,
    KBDSCN_CMD_DISP_CFG
  } kbdscn_cmd_t;

  typedef enum logic [1:0] {KBDSCN_KS_IDLE, KBDSCN_KS_DEBOUNCE, KBDSCN_KS_HELD} kbdscn_kstate_t;

  typedef enum logic [2:0] {
    KBDSCN_DISP_HEX_2X16,
    KBDSCN_DISP_HEX_32,
    KBDSCN_DISP_ALNUM_8,
    KBDSCN_DISP_ALNUM_16,
    KBDSCN_DISP_GAS_16,
    KBDSCN_DISP_GAS_18,
    KBDSCN_DISP_GAS_20,
    KBDSCN_DISP_IND_128
  } kbdscn_disp_t;

  typedef struct packed {
    logic ph1;
    logic ph2;
    logic cyc_sync;
    logic cs;
    logic [2:0] cmd;
    logic [3:0] db;
    logic [7:0] ret;
    logic shift;
    logic ctrl;
  } kbdscn_pins_t;

  typedef struct packed {
    kbdscn_pins_t meta;
    kbdscn_pins_t sync;
    logic ph2_prev;
    logic [10:0] step_cnt;
    logic [2:0] s_idx;
    logic [2:0] r_idx;
    logic half;
    logic [7:0] strobe;
    logic [1:0] nkeys;
    logic [5:0] last_code;
    logic cand_seen;
    kbdscn_kstate_t kstate;
    logic [5:0] cand;
    logic [2:0] deb_cnt;
    logic [7:0] enc_prev;
    logic [7:0][7:0] store;
    logic [2:0] wptr;
    logic [2:0] rptr;
    logic [3:0] count;
    logic overrun;
    logic blink;
    logic irq;
    logic [31:0][3:0] disp_ram;
    logic [4:0] disp_ptr;
    kbdscn_disp_t disp_cfg;
    logic [3:0] disp_a;
    logic [3:0] disp_b;
    logic [3:0] db_out;
    logic db_oe_n;
  } kbdscn_state_t;

endpackage : kbdscn_pkg

// >>> rtl/kbdscn_top.sv
/*
  Keyboard/sensor scanning, debounce, two-key rollover, shared 64-bit character
  queue / sensor store, display refresh memory, and a queued nibble command port.
  Assumes every pin input arrives asynchronously to core_clk_in and that the
  processor end issues one command per bus cycle framed by phase and sync pins.
*/
`timescale 1ns/100ps
`include "kbdscn_consts.svh"

module kbdscn_cmd_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] cnt;
    logic in_ready;
    logic out_valid;
  } kbdscn_fifo_state_t;

  localparam kbdscn_fifo_state_t FIFO_RST = '{mem: '0, wptr: '0, rptr: '0, cnt: '0, in_ready: 1'b1, out_valid: 1'b0};

  kbdscn_fifo_state_t q;
  kbdscn_fifo_state_t n;

  always_comb begin
    logic push;
    logic pop;
    push = in_valid_in & q.in_ready;
    pop = q.out_valid & out_ready_in;
    n = q;
    if (push) begin
      n.mem[q.wptr] = in_data_in;
      n.wptr = AW'(q.wptr + 1'b1);
    end
    if (pop) begin
      n.rptr = AW'(q.rptr + 1'b1);
    end
    n.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
    n.in_ready = (n.cnt != CW'(DEPTH));
    n.out_valid = (n.cnt != '0);
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= FIFO_RST;
    end else begin
      q <= n;
    end
  end

  assign in_ready_out = q.in_ready;
  assign out_valid_out = q.out_valid;
  assign out_data_out = q.mem[q.rptr];
endmodule : kbdscn_cmd_fifo

`timescale 1ns/100ps

module kbdscn_top
  import kbdscn_pkg::*;
(
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // processor bus pins
  input wire logic phase1_clk_in,
  input wire logic phase2_clk_in,
  input wire logic cycle_sync_in,
  input wire logic chip_select_line_in,
  input wire logic [2:0] command_in,
  input wire logic [3:0] data_bus_in,
  output logic [3:0] data_bus_out,
  output logic data_bus_oe_n_out,
  output logic cmd_ready_out,
  output logic int_req_out,
  // configuration
  input wire logic [1:0] kbd_mode_in,
  // key matrix
  input wire logic [7:0] return_sense_lines_in,
  input wire logic shift_in,
  input wire logic control_in,
  output logic [7:0] scan_strobe_lines_out,
  output logic display_half_select_out,
  // display outputs
  output logic [3:0] first_display_outputs_out,
  output logic [3:0] second_display_outputs_out
);
  localparam kbdscn_state_t TOP_RST = '{
    meta: '0, sync: '0, ph2_prev: 1'b0, step_cnt: '0, s_idx: '0, r_idx: '0, half: 1'b0,
    strobe: `KBDSCN_STROBE_RST, nkeys: '0, last_code: '0, cand_seen: 1'b0, kstate: KBDSCN_KS_IDLE,
    cand: '0, deb_cnt: '0, enc_prev: '0, store: '0, wptr: '0, rptr: '0, count: '0, overrun: 1'b0,
    blink: 1'b0, irq: 1'b0, disp_ram: '0, disp_ptr: '0, disp_cfg: KBDSCN_DISP_HEX_2X16,
    disp_a: '0, disp_b: '0, db_out: '0, db_oe_n: 1'b1};

  kbdscn_state_t q;
  kbdscn_state_t n;

  logic take;
  logic step_tick;
  logic cmd_valid;
  logic [`KBDSCN_CMD_WIDTH-1:0] cmd_word;

  // command accepted on a clean phase-2 rise inside a selected, synced bus cycle
  assign take = q.sync.ph2 & ~q.ph2_prev & ~q.sync.ph1 & q.sync.cyc_sync & q.sync.cs;
  assign step_tick = (q.step_cnt == `KBDSCN_STEP_W'(`KBDSCN_STEP_CYC - 1));

  // the store is written on step ticks, so commands stall for that cycle
  kbdscn_cmd_fifo #(
    .WIDTH(`KBDSCN_CMD_WIDTH),
    .DEPTH(`KBDSCN_CMD_DEPTH)
  ) u_cmd_fifo (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .in_valid_in(take),
    .in_data_in({q.sync.cmd, q.sync.db}),
    .in_ready_out(cmd_ready_out),
    .out_valid_out(cmd_valid),
    .out_data_out(cmd_word),
    .out_ready_in(~step_tick)
  );

  function automatic kbdscn_state_t push_char(input kbdscn_state_t st, input logic [7:0] ch);
    kbdscn_state_t r;
    r = st;
    if (st.count == `KBDSCN_FIFO_SLOTS) begin
      r.overrun = 1'b1;
    end else begin
      r.store[st.wptr] = ch;
      r.wptr = 3'(st.wptr + 1'b1);
      r.count = 4'(st.count + 1'b1);
    end
    return r;
  endfunction : push_char

  always_comb begin
    kbdscn_kmode_t kmode;
    logic pressed;
    logic scan_end;
    logic [1:0] nk;
    logic [5:0] here;
    logic [5:0] lc;
    logic cseen;
    logic [7:0] ch;
    logic [3:0] didx;
    kmode = kbdscn_kmode_t'(kbd_mode_in);
    pressed = 1'b0;
    scan_end = 1'b0;
    nk = q.nkeys;
    here = {q.s_idx, q.r_idx};
    lc = q.last_code;
    cseen = q.cand_seen;
    ch = '0;
    didx = '0;
    n = q;
    n.meta.ph1 = phase1_clk_in;
    n.meta.ph2 = phase2_clk_in;
    n.meta.cyc_sync = cycle_sync_in;
    n.meta.cs = chip_select_line_in;
    n.meta.cmd = command_in;
    n.meta.db = data_bus_in;
    n.meta.ret = return_sense_lines_in;
    n.meta.shift = shift_in;
    n.meta.ctrl = control_in;
    n.sync = q.meta;
    n.ph2_prev = q.sync.ph2;
    n.blink = 1'b0;
    n.step_cnt = step_tick ? '0 : `KBDSCN_STEP_W'(q.step_cnt + 1'b1);
    if (take) begin
      n.db_oe_n = 1'b1;
    end

    if (step_tick) begin
      pressed = q.sync.ret[q.r_idx];
      scan_end = (q.r_idx == `KBDSCN_LAST_IDX) && (q.s_idx == `KBDSCN_LAST_IDX);
      n.r_idx = 3'(q.r_idx + 1'b1);
      if (q.r_idx == `KBDSCN_LAST_IDX) begin
        n.s_idx = 3'(q.s_idx + 1'b1);
        n.strobe = {q.strobe[6:0], q.strobe[7]};
        if (q.s_idx == `KBDSCN_LAST_IDX) begin
          n.half = ~q.half;
        end
      end
      case (kmode)
        KBDSCN_MODE_SENSOR: begin
          if (q.r_idx == `KBDSCN_LAST_IDX) begin
            n.store[q.s_idx] = q.sync.ret;
          end
        end
        KBDSCN_MODE_ENCODED: begin
          if (scan_end) begin
            n.enc_prev = q.sync.ret;
            if ((q.sync.ret != '0) && (q.enc_prev == '0)) begin
              n = push_char(n, q.sync.ret);
            end
          end
        end
        default: begin
          // only the matrix position qualifies a key
          if (pressed) begin
            nk = (q.nkeys == 2'h2) ? 2'h2 : 2'(q.nkeys + 1'b1);
            lc = here;
            if (here == q.cand) begin
              cseen = 1'b1;
            end
          end
          n.nkeys = nk;
          n.last_code = lc;
          n.cand_seen = cseen;
          if (scan_end) begin
            n.nkeys = '0;
            n.cand_seen = 1'b0;
            case (q.kstate)
              KBDSCN_KS_IDLE: begin
                // a lone key after any release, including a rollover key left held
                if (nk == 2'h1) begin
                  n.cand = lc;
                  n.deb_cnt = '0;
                  n.kstate = KBDSCN_KS_DEBOUNCE;
                end
              end
              KBDSCN_KS_DEBOUNCE: begin
                if (q.deb_cnt == `KBDSCN_LAST_DEB) begin
                  if (cseen && (nk == 2'h1)) begin
                    ch = {q.sync.ctrl, q.sync.shift, q.cand};
                    n = push_char(n, ch);
                    n.kstate = KBDSCN_KS_HELD;
                  end else begin
                    n.kstate = KBDSCN_KS_IDLE;
                  end
                end else begin
                  n.deb_cnt = 3'(q.deb_cnt + 1'b1);
                end
              end
              KBDSCN_KS_HELD: begin
                // other keys are ignored until the accepted key is released
                if (!cseen) begin
                  n.kstate = KBDSCN_KS_IDLE;
                end
              end
              default: begin
                n.kstate = KBDSCN_KS_IDLE;
              end
            endcase
          end
        end
      endcase
    end else if (cmd_valid) begin
      case (kbdscn_cmd_t'(cmd_word[6:4]))
        KBDSCN_CMD_STATUS_RD: begin
          n.db_out = q.overrun ? `KBDSCN_OVERRUN_STATUS : q.count;
          n.db_oe_n = 1'b0;
        end
        KBDSCN_CMD_FIRST_NIBBLE_RD: begin
          n.db_out = (kmode == KBDSCN_MODE_SENSOR) ? q.store[q.disp_ptr[2:0]][7:4] : q.store[q.rptr][7:4];
          n.db_oe_n = 1'b0;
        end
        KBDSCN_CMD_SECOND_NIBBLE_READ_CMD: begin
          n.db_out = (kmode == KBDSCN_MODE_SENSOR) ? q.store[q.disp_ptr[2:0]][3:0] : q.store[q.rptr][3:0];
          n.db_oe_n = 1'b0;
          if ((kmode != KBDSCN_MODE_SENSOR) && (q.count != '0)) begin
            n.rptr = 3'(q.rptr + 1'b1);
            n.count = 4'(q.count - 1'b1);
            n.blink = 1'b1;
          end
        end
        KBDSCN_CMD_CLEAR_LOGIC_CMD, KBDSCN_CMD_ALTERNATE_CLEAR_CMD: begin
          n.store = '0;
          n.wptr = '0;
          n.rptr = '0;
          n.count = '0;
          n.overrun = 1'b0;
        end
        KBDSCN_CMD_DISP_WR: begin
          n.disp_ram[q.disp_ptr] = cmd_word[3:0];
          n.disp_ptr = 5'(q.disp_ptr + 1'b1);
        end
        KBDSCN_CMD_DISP_PTR: begin
          n.disp_ptr = {1'b0, cmd_word[3:0]};
        end
        KBDSCN_CMD_DISP_CFG: begin
          n.disp_cfg = kbdscn_disp_t'(cmd_word[2:0]);
        end
        default: begin
          n.db_oe_n = 1'b1;
        end
      endcase
    end

    // eight-digit organisation shows the same digit on both scan halves
    didx = (q.disp_cfg == KBDSCN_DISP_ALNUM_8) ? {1'b0, q.s_idx} : {q.half, q.s_idx};
    n.disp_a = q.disp_ram[{1'b0, didx}];
    n.disp_b = q.disp_ram[{1'b1, didx}];

    // outside sensor mode and with no overrun flagged, the request drops for one cycle per character read so the processor sees each character
    if (kmode == KBDSCN_MODE_SENSOR) begin
      n.irq = (n.store != '0);
    end else begin
      n.irq = n.overrun | ((n.count != '0) & ~n.blink);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q <= TOP_RST;
    end else begin
      q <= n;
    end
  end

  assign data_bus_out = q.db_out;
  assign data_bus_oe_n_out = q.db_oe_n;
  assign int_req_out = q.irq;
  assign scan_strobe_lines_out = q.strobe;
  assign display_half_select_out = q.half;
  assign first_display_outputs_out = q.disp_a;
  assign second_display_outputs_out = q.disp_b;
endmodule : kbdscn_top

// >>> verif/kbdscn_monitor.sv
/*
  Port-level assertion checker for the keyboard scan block, bound onto kbdscn_top.
  Assumes the constants header is on the include path and a single core clock.
*/
`timescale 1ns/100ps
`include "kbdscn_consts.svh"
module kbdscn_monitor (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // processor side
  input wire logic phase2_clk_in,
  input wire logic chip_select_line_in,
  input wire logic [3:0] data_bus_out,
  input wire logic data_bus_oe_n_out,
  input wire logic cmd_ready_out,
  input wire logic int_req_out,
  // matrix side
  input wire logic [7:0] scan_strobe_lines_out,
  input wire logic display_half_select_out
);
  localparam int STROBE_GAP = 8 * `KBDSCN_STEP_CYC;
  logic [7:0] strobe_q_r;
  logic [15:0] gap_r;
  logic seen_r;

  // gap is only trusted after one change, the first dwell depends on reset phase
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strobe_q_r <= 8'h01;
      gap_r <= 16'h0000;
      seen_r <= 1'b0;
    end else begin
      strobe_q_r <= scan_strobe_lines_out;
      if (scan_strobe_lines_out != strobe_q_r) begin
        gap_r <= 16'h0001;
        seen_r <= 1'b1;
      end else begin
        gap_r <= gap_r + 16'h0001;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence wrap_seq;
    $changed(scan_strobe_lines_out) && scan_strobe_lines_out == 8'h01;
  endsequence

  strobe_onehot_a: assert property ($onehot(scan_strobe_lines_out))
    else $error("strobe not one-hot");
  strobe_shift_a: assert property ($changed(scan_strobe_lines_out) |->
    scan_strobe_lines_out == {strobe_q_r[6:0], strobe_q_r[7]}) else $error("strobe did not step by one");
  wrap_toggle_a: assert property (wrap_seq |-> $changed(display_half_select_out))
    else $error("half select missed wrap");
  half_hold_a: assert property ($changed(display_half_select_out) |-> strobe_q_r == 8'h80)
    else $error("half select toggled mid pass");
  strobe_gap_a: assert property ((scan_strobe_lines_out != strobe_q_r && seen_r) |-> gap_r == STROBE_GAP)
    else $error("strobe dwell wrong");
  reset_state_a: assert property (!$past(resetn_in) |-> scan_strobe_lines_out == 8'h01 &&
    !display_half_select_out && !int_req_out && data_bus_oe_n_out && cmd_ready_out) else $error("bad reset state");
  answer_frame_a: assert property ($fell(data_bus_oe_n_out) |-> $past(chip_select_line_in, 4))
    else $error("bus driven without a selected frame");
  answer_hold_a: assert property ((!data_bus_oe_n_out && $stable(data_bus_oe_n_out) &&
    !$past(phase2_clk_in, 3) && !$past(phase2_clk_in, 6)) |-> $stable(data_bus_out)) else $error("answer moved");
endmodule : kbdscn_monitor

bind kbdscn_top kbdscn_monitor u_mon (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .phase2_clk_in(phase2_clk_in), .chip_select_line_in(chip_select_line_in), .data_bus_out(data_bus_out),
  .data_bus_oe_n_out(data_bus_oe_n_out), .cmd_ready_out(cmd_ready_out), .int_req_out(int_req_out),
  .scan_strobe_lines_out(scan_strobe_lines_out), .display_half_select_out(display_half_select_out));

// >>> verif/kbdscn_cpu_model.sv
/*
  Processor end of the nibble bus: phase clocks, sync, chip select, command and data.
  Assumes the caller invokes xfer from one process at a time.
*/
`timescale 1ns/100ps
module kbdscn_cpu_model (
  // clock
  input wire logic core_clk_in,
  // bus pins driven by the processor
  output logic phase1_clk_out,
  output logic phase2_clk_out,
  output logic cycle_sync_out,
  output logic chip_select_out,
  output logic [2:0] command_out,
  output logic [3:0] data_bus_out,
  // answer from the device
  input wire logic [3:0] data_bus_in,
  input wire logic data_bus_oe_n_in
);
  initial begin
    phase1_clk_out = 1'b0;
    phase2_clk_out = 1'b0;
    cycle_sync_out = 1'b0;
    chip_select_out = 1'b0;
    command_out = 3'h0;
    data_bus_out = 4'h0;
  end

  // pins stand several core cycles each since the device double-syncs them
  task automatic xfer(input logic [2:0] op, input logic [3:0] wd, output logic [3:0] rd, output logic rd_oe_n);
    @(posedge core_clk_in);
    #2;
    phase1_clk_out = 1'b1;
    cycle_sync_out = 1'b1;
    chip_select_out = 1'b1;
    command_out = op;
    data_bus_out = wd;
    repeat (3) @(posedge core_clk_in);
    #2;
    phase1_clk_out = 1'b0;
    repeat (3) @(posedge core_clk_in);
    #2;
    phase2_clk_out = 1'b1;
    repeat (6) @(posedge core_clk_in);
    #2;
    rd = data_bus_in;
    rd_oe_n = data_bus_oe_n_in;
    phase2_clk_out = 1'b0;
    repeat (2) @(posedge core_clk_in);
    #2;
    chip_select_out = 1'b0;
    cycle_sync_out = 1'b0;
    // released bus shows no stale value
    data_bus_out = ~wd;
  endtask : xfer
endmodule : kbdscn_cpu_model

// >>> verif/kbdscn_bench.sv
/*
  Self-checking bench for the keyboard scan block: reset state, bus reads, strobe pacing, sensor capture.
  Assumes the processor model and the bound monitor are compiled alongside.
*/
`timescale 1ns/100ps
`include "kbdscn_consts.svh"
module kbdscn_bench;
  import kbdscn_pkg::*;
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] kbd_mode = 2'h0;
  logic [7:0] ret = 8'h00;
  logic ph1, ph2, sync, cs, oe_n, rdy, irq, half;
  logic [2:0] cmd;
  logic [3:0] db_in, db_out, rd, disp_a, disp_b;
  logic rd_oe_n;
  logic [7:0] strobe;
  logic [7:0] sense_grid [8] = '{default: 8'h00};
  int errors = 0;
  int tests_run = 0;
  int n;

  always #12.5 core_clk_in = ~core_clk_in;

  kbdscn_cpu_model u_cpu (.core_clk_in(core_clk_in), .phase1_clk_out(ph1), .phase2_clk_out(ph2),
    .cycle_sync_out(sync), .chip_select_out(cs), .command_out(cmd), .data_bus_out(db_in),
    .data_bus_in(db_out), .data_bus_oe_n_in(oe_n));

  kbdscn_top u_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in), .phase1_clk_in(ph1),
    .phase2_clk_in(ph2), .cycle_sync_in(sync), .chip_select_line_in(cs), .command_in(cmd),
    .data_bus_in(db_in), .data_bus_out(db_out), .data_bus_oe_n_out(oe_n), .cmd_ready_out(rdy),
    .int_req_out(irq), .kbd_mode_in(kbd_mode), .return_sense_lines_in(ret), .shift_in(1'b1),
    .control_in(1'b0), .scan_strobe_lines_out(strobe), .display_half_select_out(half),
    .first_display_outputs_out(disp_a), .second_display_outputs_out(disp_b));

  function automatic logic [7:0] grid_lines(input logic [7:0] s);
    logic [7:0] acc;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) if (s[i]) acc = acc | sense_grid[i];
    return acc;
  endfunction : grid_lines

  // closed contacts return high only on the strobed line; open lines are pulled down
  always @(posedge core_clk_in) begin
    #2;
    ret = grid_lines(strobe);
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [2:0] op, input logic [3:0] exp, input string what);
    u_cpu.xfer(op, 4'h0, rd, rd_oe_n);
    chk({15'h0000, rd_oe_n}, 16'h0000, "bus not driven");
    chk({12'h000, rd}, {12'h000, exp}, what);
  endtask : rd_chk

  task automatic do_reset(input logic [1:0] mode);
    @(posedge core_clk_in);
    #2;
    resetn_in = 1'b0;
    kbd_mode = mode;
    repeat (16) @(posedge core_clk_in);
    #2;
    resetn_in = 1'b1;
  endtask : do_reset

  task automatic wait_strobe(input logic [7:0] want);
    n = 0;
    while (strobe !== want) begin
      @(posedge core_clk_in);
      #2;
      n++;
      if (n > 9 * `KBDSCN_STEP_CYC) begin
        errors++;
        $display("[FAIL] %0t strobe never reached %h", $time, want);
        stop_test();
      end
    end
  endtask : wait_strobe

  task automatic t_reset_state;
    chk({8'h00, strobe}, 16'h0001, "strobe after reset");
    chk({12'h000, half, irq, oe_n, rdy}, 16'h0003, "flags after reset");
    $display("reset state done");
  endtask : t_reset_state

  task automatic t_empty_reads;
    rd_chk(KBDSCN_CMD_STATUS_RD, 4'h0, "empty status");
    rd_chk(KBDSCN_CMD_FIRST_NIBBLE_RD, 4'h0, "empty first nibble");
    rd_chk(KBDSCN_CMD_SECOND_NIBBLE_READ_CMD, 4'h0, "empty second nibble");
    rd_chk(KBDSCN_CMD_STATUS_RD, 4'h0, "status after empty advance");
    $display("empty reads done");
  endtask : t_empty_reads

  // runs early after reset so the scan still sits on digit zero of the first half
  task automatic t_display;
    u_cpu.xfer(KBDSCN_CMD_DISP_PTR, 4'h0, rd, rd_oe_n);
    u_cpu.xfer(KBDSCN_CMD_DISP_WR, 4'h6, rd, rd_oe_n);
    u_cpu.xfer(KBDSCN_CMD_DISP_PTR, 4'hF, rd, rd_oe_n);
    u_cpu.xfer(KBDSCN_CMD_DISP_WR, 4'h3, rd, rd_oe_n);
    u_cpu.xfer(KBDSCN_CMD_DISP_WR, 4'h9, rd, rd_oe_n);
    @(posedge core_clk_in);
    #2;
    chk({8'h00, disp_a, disp_b}, 16'h0069, "digit zero of both halves");
    chk({15'h0000, rd_oe_n}, 16'h0001, "bus driven on a write");
    $display("display done");
  endtask : t_display

  task automatic t_strobe_step;
    wait_strobe(8'h02);
    wait_strobe(8'h04);
    chk(16'(n), 16'(8 * `KBDSCN_STEP_CYC), "dwell per scan line");
    $display("strobe step done");
  endtask : t_strobe_step

  task automatic t_sensor;
    sense_grid[0] = 8'h5A;
    do_reset(2'h2);
    wait_strobe(8'h02);
    repeat (4) @(posedge core_clk_in);
    #2;
    chk({15'h0000, irq}, 16'h0001, "sensor hit interrupt");
    rd_chk(KBDSCN_CMD_FIRST_NIBBLE_RD, 4'h5, "sensor upper nibble");
    rd_chk(KBDSCN_CMD_SECOND_NIBBLE_READ_CMD, 4'hA, "sensor lower nibble");
    rd_chk(KBDSCN_CMD_SECOND_NIBBLE_READ_CMD, 4'hA, "sensor read kept");
    sense_grid[0] = 8'h00;
    u_cpu.xfer(KBDSCN_CMD_CLEAR_LOGIC_CMD, 4'h0, rd, rd_oe_n);
    repeat (4) @(posedge core_clk_in);
    #2;
    chk({15'h0000, irq}, 16'h0000, "interrupt after clear");
    rd_chk(KBDSCN_CMD_FIRST_NIBBLE_RD, 4'h0, "store after clear");
    $display("sensor done");
  endtask : t_sensor

  initial begin
    do_reset(2'h0);
    t_reset_state();
    t_empty_reads();
    t_display();
    t_strobe_step();
    t_sensor();
    stop_test();
  end
endmodule : kbdscn_bench
